// File: design/achr_pkg.sv
// Constants and carrier types of the receive cell handler register bank.
// Assumes byte-wide registers, each on one aligned 32-bit APB word.
package achr_pkg;

  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned IDX_W    = 5;
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned BYTE_W   = 8;

  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_HOLD_MID    = 5'h00;
  localparam logic [4:0] IDX_HOLD_TOP    = 5'h01;
  localparam logic [4:0] IDX_CNT_EN      = 5'h02;
  localparam logic [4:0] IDX_RST_HALT    = 5'h03;
  localparam logic [4:0] IDX_CMD         = 5'h04;
  localparam logic [4:0] IDX_STATUS      = 5'h05;
  localparam logic [4:0] IDX_TOP_PEND    = 5'h06;
  localparam logic [4:0] IDX_TOP_MASK    = 5'h07;
  localparam logic [4:0] IDX_CNT_PEND    = 5'h08;
  localparam logic [4:0] IDX_CNT_MASK    = 5'h09;
  localparam logic [4:0] IDX_OP_MODE     = 5'h0A;
  localparam logic [4:0] IDX_CELL_SYNC   = 5'h0B;
  localparam logic [4:0] IDX_AF_LEVEL    = 5'h0C;
  localparam logic [4:0] IDX_PATTERN0    = 5'h0D;
  localparam logic [4:0] IDX_PATTERN3    = 5'h10;
  localparam logic [4:0] IDX_FILLER      = 5'h11;
  localparam logic [4:0] IDX_FIFO_CLR    = 5'h12;
  localparam logic [4:0] IDX_FIFO_CNT    = 5'h13;
  localparam logic [4:0] IDX_IDLE_CLR    = 5'h14;
  localparam logic [4:0] IDX_IDLE_CNT    = 5'h15;
  localparam logic [4:0] IDX_HEC_CLR     = 5'h16;
  localparam logic [4:0] IDX_HEC_CNT     = 5'h17;
  localparam logic [4:0] IDX_HEC_LIM_HI  = 5'h18;
  localparam logic [4:0] IDX_HEC_LIM_LO  = 5'h19;
  localparam logic [4:0] IDX_DISC_CLR    = 5'h1A;
  localparam logic [4:0] IDX_DISC_CNT    = 5'h1B;
  localparam logic [4:0] IDX_DISC_LIM_HI = 5'h1C;
  localparam logic [4:0] IDX_DISC_LIM_LO = 5'h1D;
  localparam logic [4:0] IDX_LAST        = 5'h1D;

  // Counter widths
  localparam int unsigned FIFO_CNT_W = 24;
  localparam int unsigned IDLE_CNT_W = 24;
  localparam int unsigned HEC_CNT_W  = 16;
  localparam int unsigned DISC_CNT_W = 16;

  // Field positions
  localparam int unsigned CNT_EN_FIFO     = 0;
  localparam int unsigned CNT_EN_IDLE     = 1;
  localparam int unsigned CNT_EN_HEC      = 2;
  localparam int unsigned CNT_EN_DISC     = 3;
  localparam int unsigned RST_BIT         = 0;
  localparam int unsigned HALT_BIT        = 1;
  localparam int unsigned OPM_STAT_ON_RD  = 1;
  localparam int unsigned OPM_IRQ_ON_RD   = 7;
  localparam int unsigned TOP_FATAL       = 0;
  localparam int unsigned TOP_CNT_PTR     = 1;
  localparam int unsigned PEND_FIFO_OVF   = 0;
  localparam int unsigned PEND_IDLE_OVF   = 1;
  localparam int unsigned PEND_HEC_OVF    = 2;
  localparam int unsigned PEND_HEC_LIM    = 3;
  localparam int unsigned PEND_DISC_OVF   = 4;
  localparam int unsigned PEND_DISC_LIM   = 5;

  // Reset values
  localparam logic [7:0] RST_HALT_DEF  = 8'h01;
  localparam logic [7:0] CNT_EN_DEF    = 8'h00;
  localparam logic [7:0] MASK_DEF      = 8'h00;
  localparam logic [7:0] CONF_DEF      = 8'h00;
  localparam logic [7:0] LIMIT_DEF     = 8'hFF;
  localparam logic [7:0] PATTERN_DEF   = 8'h00;

  typedef struct packed {
    logic [7:0]      opMode;
    logic [7:0]      cellSync;
    logic [7:0]      almostFullLevel;
    logic [3:0][7:0] idlePattern;
    logic [7:0]      alignFiller;
  } achr_cfg_t;

  typedef struct packed {
    logic       fifoWritten;
    logic       idleCell;
    logic       hecError;
    logic       discarded;
    logic       fatal;
    logic [7:0] status;
  } achr_evt_t;

endpackage

// File: design/achr_counter.sv
// Saturation-free event counter with clear-after-read and overflow pulse.
// Assumes inc, enable and clear come from logic on the same clock.
module achr_counter #(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             inc,
  input  wire logic             enable,
  input  wire logic             clear,
  output logic      [WIDTH-1:0] count,
  output logic                  overflow
);

  logic step;

  assign step = inc & enable;

  // An event in the clearing cycle is kept as the first new count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (clear) begin
      count <= step ? WIDTH'(1) : '0;
    end else if (step) begin
      count <= count + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overflow <= 1'b0;
    end else begin
      overflow <= step & ~clear & (&count);
    end
  end

endmodule

// File: design/achr_regs.sv
// Register bank of the receive cell handler: counters, holding bytes, control,
// status, two-level interrupt tree and cell path configuration, on APB.
// Assumes chiplet events and chipletResetIn are synchronous to clk.
//
// What this block does
// - Reading counter address N or N-1 returns the low byte.
// - Read at N keeps count; read at N-1 clears it after delivery.
// - Any counter read first latches upper bytes into holding registers.
// - Two holding registers give middle and top byte of captured count.
// - 24-bit count of cells written to FIFO; overflow raises request.
// - 24-bit count of idle cells received; overflow raises request.
// - 16-bit count of header check errors; overflow raises request.
// - Header error count above two-byte limit raises request.
// - 16-bit count of cells discarded on FIFO full; overflow raises request.
// - Discard count above two-byte limit raises request.
// - Each counter has an enable bit: 0 stops, 1 counts while reset bit 0 of the reset/halt register is clear.
// - Reset/halt register forced to default by chiplet reset input.
// - Writing 1 to a command bit gives a one-cycle pulse.
// - Status bits latch chiplet events until software clears them.
// - Latch and interrupt bits clear by write-one or by read, selectable.
// - Top register shows fatal bit and pointer for pending counter requests.
// - Bit 0 of top register is fatal, set on any fatal event.
// - Top mask 0 blocks, 1 lets pending bit drive interrupt line.
// - Counter pending bits per event; enabled ones set the pointer bit.
// - Programmable almost-full level for the external FIFO.
// - Four programmable header patterns recognise idle cells.
// - Programmable filler byte aligns payload in receive buffer.
// - Configuration register holds cell synchronisation controls.
module achr_regs (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     chipletResetIn,
  input  wire achr_pkg::achr_evt_t      evt,
  output achr_pkg::achr_cfg_t           cfg,
  output logic                          chipletReset,
  output logic                          chipletHalt,
  output logic      [7:0]               cmdPulse,
  output logic                          handlerIrq
);

  logic [4:0]                        idx;
  logic                              mapped;
  logic                              accTake;
  logic                              rdAcc;
  logic                              wrAcc;
  logic                              ackd_r;
  logic [7:0]                        wbyte;
  logic [7:0]                        rbyte;

  logic [7:0]                        holdMid_r;
  logic [7:0]                        holdTop_r;
  logic [7:0]                        cntEn_r;
  logic [7:0]                        rstHalt_r;
  logic [7:0]                        cmd_r;
  logic [7:0]                        status_r;
  logic                              fatal_r;
  logic [7:0]                        topMask_r;
  logic [7:0]                        cntPend_r;
  logic [7:0]                        cntMask_r;
  logic [7:0]                        hecLimHi_r;
  logic [7:0]                        hecLimLo_r;
  logic [7:0]                        discLimHi_r;
  logic [7:0]                        discLimLo_r;
  logic                              hecOver_r;
  logic                              discOver_r;
  logic                              irq_r;
  achr_pkg::achr_cfg_t               cfg_r;

  logic [achr_pkg::FIFO_CNT_W-1:0]   fifoCnt;
  logic [achr_pkg::IDLE_CNT_W-1:0]   idleCnt;
  logic [achr_pkg::HEC_CNT_W-1:0]    hecCnt;
  logic [achr_pkg::DISC_CNT_W-1:0]   discCnt;
  logic                              fifoOvf;
  logic                              idleOvf;
  logic                              hecOvf;
  logic                              discOvf;
  logic                              countAllowed;
  logic                              hecOver;
  logic                              discOver;
  logic [7:0]                        topPending;
  logic [7:0]                        statusClr;
  logic [7:0]                        cntPendClr;
  logic                              fatalClr;
  logic [7:0]                        cntPendSet;

  // Bus decode: one wait state, effects at the end of the first access cycle
  assign idx     = paddr[achr_pkg::IDX_LSB +: achr_pkg::IDX_W];
  assign mapped  = ~paddr[7] & (paddr[1:0] == 2'b00) & (idx <= achr_pkg::IDX_LAST);
  assign accTake = psel & penable & ~ackd_r;
  assign rdAcc   = accTake & ~pwrite & mapped;
  assign wrAcc   = accTake & pwrite & mapped;
  assign wbyte   = pwdata[7:0];
  assign pready  = ackd_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ackd_r  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      ackd_r  <= accTake;
      if (accTake) begin
        pslverr <= ~mapped;
        prdata  <= {24'h0000_00, (pwrite | ~mapped) ? 8'h00 : rbyte};
      end
    end
  end

  assign countAllowed = ~rstHalt_r[achr_pkg::RST_BIT];

  achr_counter #(.WIDTH(achr_pkg::FIFO_CNT_W)) u_fifoCnt (
    .clk      (clk),
    .nrst     (nrst),
    .inc      (evt.fifoWritten),
    .enable   (cntEn_r[achr_pkg::CNT_EN_FIFO] & countAllowed),
    .clear    (rdAcc & (idx == achr_pkg::IDX_FIFO_CLR)),
    .count    (fifoCnt),
    .overflow (fifoOvf)
  );

  achr_counter #(.WIDTH(achr_pkg::IDLE_CNT_W)) u_idleCnt (
    .clk      (clk),
    .nrst     (nrst),
    .inc      (evt.idleCell),
    .enable   (cntEn_r[achr_pkg::CNT_EN_IDLE] & countAllowed),
    .clear    (rdAcc & (idx == achr_pkg::IDX_IDLE_CLR)),
    .count    (idleCnt),
    .overflow (idleOvf)
  );

  achr_counter #(.WIDTH(achr_pkg::HEC_CNT_W)) u_hecCnt (
    .clk      (clk),
    .nrst     (nrst),
    .inc      (evt.hecError),
    .enable   (cntEn_r[achr_pkg::CNT_EN_HEC] & countAllowed),
    .clear    (rdAcc & (idx == achr_pkg::IDX_HEC_CLR)),
    .count    (hecCnt),
    .overflow (hecOvf)
  );

  achr_counter #(.WIDTH(achr_pkg::DISC_CNT_W)) u_discCnt (
    .clk      (clk),
    .nrst     (nrst),
    .inc      (evt.discarded),
    .enable   (cntEn_r[achr_pkg::CNT_EN_DISC] & countAllowed),
    .clear    (rdAcc & (idx == achr_pkg::IDX_DISC_CLR)),
    .count    (discCnt),
    .overflow (discOvf)
  );

  // capture upper bytes on any counter read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      holdMid_r <= 8'h00;
      holdTop_r <= 8'h00;
    end else if (rdAcc) begin
      case (idx)
        achr_pkg::IDX_FIFO_CLR, achr_pkg::IDX_FIFO_CNT: begin
          holdMid_r <= fifoCnt[15:8];
          holdTop_r <= fifoCnt[23:16];
        end
        achr_pkg::IDX_IDLE_CLR, achr_pkg::IDX_IDLE_CNT: begin
          holdMid_r <= idleCnt[15:8];
          holdTop_r <= idleCnt[23:16];
        end
        achr_pkg::IDX_HEC_CLR, achr_pkg::IDX_HEC_CNT: begin
          holdMid_r <= hecCnt[15:8];
          holdTop_r <= 8'h00;
        end
        achr_pkg::IDX_DISC_CLR, achr_pkg::IDX_DISC_CNT: begin
          holdMid_r <= discCnt[15:8];
          holdTop_r <= 8'h00;
        end
        default: begin
          holdMid_r <= holdMid_r;
          holdTop_r <= holdTop_r;
        end
      endcase
    end
  end

  // header error and discard limits, event on crossing
  assign hecOver  = hecCnt > {hecLimHi_r, hecLimLo_r};
  assign discOver = discCnt > {discLimHi_r, discLimLo_r};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hecOver_r  <= 1'b0;
      discOver_r <= 1'b0;
    end else begin
      hecOver_r  <= hecOver;
      discOver_r <= discOver;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hecLimHi_r  <= achr_pkg::LIMIT_DEF;
      hecLimLo_r  <= achr_pkg::LIMIT_DEF;
      discLimHi_r <= achr_pkg::LIMIT_DEF;
      discLimLo_r <= achr_pkg::LIMIT_DEF;
      cntEn_r     <= achr_pkg::CNT_EN_DEF;
    end else if (wrAcc) begin
      case (idx)
        achr_pkg::IDX_HEC_LIM_HI:  hecLimHi_r  <= wbyte;
        achr_pkg::IDX_HEC_LIM_LO:  hecLimLo_r  <= wbyte;
        achr_pkg::IDX_DISC_LIM_HI: discLimHi_r <= wbyte;
        achr_pkg::IDX_DISC_LIM_LO: discLimLo_r <= wbyte;
        achr_pkg::IDX_CNT_EN:      cntEn_r     <= wbyte;
        default:                   cntEn_r     <= cntEn_r;
      endcase
    end
  end

  // reset/halt forced to default by chiplet reset input
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstHalt_r <= achr_pkg::RST_HALT_DEF;
    end else if (chipletResetIn) begin
      rstHalt_r <= achr_pkg::RST_HALT_DEF;
    end else if (wrAcc && idx == achr_pkg::IDX_RST_HALT) begin
      rstHalt_r <= {6'b00_0000, wbyte[1:0]};
    end else begin
      rstHalt_r <= rstHalt_r;
    end
  end

  assign chipletReset = rstHalt_r[achr_pkg::RST_BIT];
  assign chipletHalt  = rstHalt_r[achr_pkg::HALT_BIT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_r <= 8'h00;
    end else begin
      cmd_r <= (wrAcc && idx == achr_pkg::IDX_CMD) ? wbyte : 8'h00;
    end
  end

  assign cmdPulse = cmd_r;

  // clear selection: write-one or read, chosen per register class
  always_comb begin
    statusClr  = 8'h00;
    cntPendClr = 8'h00;
    fatalClr   = 1'b0;
    if (cfg_r.opMode[achr_pkg::OPM_STAT_ON_RD]) begin
      if (rdAcc && idx == achr_pkg::IDX_STATUS) begin
        statusClr = 8'hFF;
      end
    end else if (wrAcc && idx == achr_pkg::IDX_STATUS) begin
      statusClr = wbyte;
    end
    if (cfg_r.opMode[achr_pkg::OPM_IRQ_ON_RD]) begin
      if (rdAcc && idx == achr_pkg::IDX_CNT_PEND) begin
        cntPendClr = 8'hFF;
      end
      fatalClr = rdAcc && idx == achr_pkg::IDX_TOP_PEND;
    end else begin
      if (wrAcc && idx == achr_pkg::IDX_CNT_PEND) begin
        cntPendClr = wbyte;
      end
      fatalClr = wrAcc && idx == achr_pkg::IDX_TOP_PEND && wbyte[achr_pkg::TOP_FATAL];
    end
  end

  always_comb begin
    cntPendSet = 8'h00;
    cntPendSet[achr_pkg::PEND_FIFO_OVF] = fifoOvf;
    cntPendSet[achr_pkg::PEND_IDLE_OVF] = idleOvf;
    cntPendSet[achr_pkg::PEND_HEC_OVF]  = hecOvf;
    cntPendSet[achr_pkg::PEND_HEC_LIM]  = hecOver & ~hecOver_r;
    cntPendSet[achr_pkg::PEND_DISC_OVF] = discOvf;
    cntPendSet[achr_pkg::PEND_DISC_LIM] = discOver & ~discOver_r;
  end

  // sticky status; a new event wins over the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_r  <= 8'h00;
      cntPend_r <= 8'h00;
      fatal_r   <= 1'b0;
    end else begin
      status_r  <= (status_r & ~statusClr) | evt.status;
      cntPend_r <= (cntPend_r & ~cntPendClr) | cntPendSet;
      fatal_r   <= (fatal_r & ~fatalClr) | evt.fatal;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      topMask_r <= achr_pkg::MASK_DEF;
      cntMask_r <= achr_pkg::MASK_DEF;
    end else if (wrAcc && idx == achr_pkg::IDX_TOP_MASK) begin
      topMask_r <= wbyte;
    end else if (wrAcc && idx == achr_pkg::IDX_CNT_MASK) begin
      cntMask_r <= wbyte;
    end else begin
      topMask_r <= topMask_r;
    end
  end

  // top register: fatal bit and counter pointer
  always_comb begin
    topPending = 8'h00;
    topPending[achr_pkg::TOP_FATAL]   = fatal_r;
    topPending[achr_pkg::TOP_CNT_PTR] = |(cntPend_r & cntMask_r);
  end

  // masked top level drives the interrupt line
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(topPending & topMask_r);
    end
  end

  assign handlerIrq = irq_r;

  // almost-full level, idle patterns, filler, sync control
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r.opMode          <= achr_pkg::CONF_DEF;
      cfg_r.cellSync        <= achr_pkg::CONF_DEF;
      cfg_r.almostFullLevel <= achr_pkg::CONF_DEF;
      cfg_r.idlePattern     <= {4{achr_pkg::PATTERN_DEF}};
      cfg_r.alignFiller     <= achr_pkg::PATTERN_DEF;
    end else if (wrAcc) begin
      case (idx)
        achr_pkg::IDX_OP_MODE:   cfg_r.opMode          <= wbyte;
        achr_pkg::IDX_CELL_SYNC: cfg_r.cellSync        <= wbyte;
        achr_pkg::IDX_AF_LEVEL:  cfg_r.almostFullLevel <= wbyte;
        achr_pkg::IDX_FILLER:    cfg_r.alignFiller     <= wbyte;
        default: begin
          if (idx >= achr_pkg::IDX_PATTERN0 && idx <= achr_pkg::IDX_PATTERN3) begin
            cfg_r.idlePattern[2'(idx - achr_pkg::IDX_PATTERN0)] <= wbyte;
          end
        end
      endcase
    end
  end

  assign cfg = cfg_r;

  // both counter addresses return the low byte
  always_comb begin
    rbyte = 8'h00;
    case (idx)
      achr_pkg::IDX_HOLD_MID:    rbyte = holdMid_r;
      achr_pkg::IDX_HOLD_TOP:    rbyte = holdTop_r;
      achr_pkg::IDX_CNT_EN:      rbyte = cntEn_r;
      achr_pkg::IDX_RST_HALT:    rbyte = rstHalt_r;
      achr_pkg::IDX_CMD:         rbyte = 8'h00;
      achr_pkg::IDX_STATUS:      rbyte = status_r;
      achr_pkg::IDX_TOP_PEND:    rbyte = topPending;
      achr_pkg::IDX_TOP_MASK:    rbyte = topMask_r;
      achr_pkg::IDX_CNT_PEND:    rbyte = cntPend_r;
      achr_pkg::IDX_CNT_MASK:    rbyte = cntMask_r;
      achr_pkg::IDX_OP_MODE:     rbyte = cfg_r.opMode;
      achr_pkg::IDX_CELL_SYNC:   rbyte = cfg_r.cellSync;
      achr_pkg::IDX_AF_LEVEL:    rbyte = cfg_r.almostFullLevel;
      achr_pkg::IDX_FILLER:      rbyte = cfg_r.alignFiller;
      achr_pkg::IDX_FIFO_CLR,
      achr_pkg::IDX_FIFO_CNT:    rbyte = fifoCnt[7:0];
      achr_pkg::IDX_IDLE_CLR,
      achr_pkg::IDX_IDLE_CNT:    rbyte = idleCnt[7:0];
      achr_pkg::IDX_HEC_CLR,
      achr_pkg::IDX_HEC_CNT:     rbyte = hecCnt[7:0];
      achr_pkg::IDX_HEC_LIM_HI:  rbyte = hecLimHi_r;
      achr_pkg::IDX_HEC_LIM_LO:  rbyte = hecLimLo_r;
      achr_pkg::IDX_DISC_CLR,
      achr_pkg::IDX_DISC_CNT:    rbyte = discCnt[7:0];
      achr_pkg::IDX_DISC_LIM_HI: rbyte = discLimHi_r;
      achr_pkg::IDX_DISC_LIM_LO: rbyte = discLimLo_r;
      default: begin
        if (idx >= achr_pkg::IDX_PATTERN0 && idx <= achr_pkg::IDX_PATTERN3) begin
          rbyte = cfg_r.idlePattern[2'(idx - achr_pkg::IDX_PATTERN0)];
        end
      end
    endcase
  end

endmodule

// File: dv/achr_regs_asserts.sv
// Checker of the register bank ports.
// Assumes it is bound into achr_regs.
module achr_regs_asserts (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        chipletResetIn,
  input wire logic        chipletReset,
  input wire logic        chipletHalt,
  input wire logic [7:0]  cmdPulse,
  input wire logic        handlerIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  assign take = psel && penable && !pready;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_answer; take |=> pready ##1 !pready; endproperty
  a_answer: assert property (p_answer) else $error("bad answer");
  property p_unmapped; pready && paddr[7] |-> pslverr && prdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  property p_cmdWrite; take && pwrite && paddr == 8'h10 |=> cmdPulse == $past(pwdata[7:0]);
  endproperty
  a_cmdWrite: assert property (p_cmdWrite) else $error("no pulse");
  property p_cmdOnce; cmdPulse != 8'h00 |=> cmdPulse == 8'h00; endproperty
  a_cmdOnce: assert property (p_cmdOnce) else $error("long pulse");
  property p_cmdRead; pready && !pwrite && paddr == 8'h10 |-> prdata == 32'h0000_0000;
  endproperty
  a_cmdRead: assert property (p_cmdRead) else $error("cmd reads");
  property p_rstIn; chipletResetIn |=> chipletReset && !chipletHalt; endproperty
  a_rstIn: assert property (p_rstIn) else $error("reset in");
  property p_rstWrite; take && pwrite && paddr == 8'h0C && !chipletResetIn
    |=> {chipletHalt, chipletReset} == $past(pwdata[1:0]); endproperty
  a_rstWrite: assert property (p_rstWrite) else $error("reset write");
  property p_irqMasked; pready && !pwrite && paddr inside {8'h18, 8'h1C}
    && prdata[7:0] == 8'h00 |-> !handlerIrq; endproperty
  a_irqMasked: assert property (p_irqMasked) else $error("irq leak");
endmodule

bind achr_regs achr_regs_asserts i_chk (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .chipletResetIn, .chipletReset, .chipletHalt,
  .cmdPulse, .handlerIrq);

// File: dv/achr_evt_src.sv
// Chiplet event source facing the register bank.
// Assumes the bench calls burst from its main sequence.
module achr_evt_src (
  input  wire logic          clk,
  output achr_pkg::achr_evt_t evt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial evt = '0;
  // One-cycle pulses with a gap, as the chiplet raises them
  task automatic burst(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      evt[k] <= 1'h1;
      @(posedge clk);
      evt[k] <= 1'h0;
    end
  endtask
endmodule

// File: dv/achr_regs_test.sv
// Self-checking bench of the receive cell handler register bank.
// Assumes APB answers after one wait state; events come from achr_evt_src.
module achr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, nrst, psel, penable, pwrite, pready, pslverr, qErr;
  logic                chipletResetIn, chipletReset, chipletHalt, handlerIrq;
  logic [7:0]          paddr, cmdPulse;
  logic [31:0]         pwdata, prdata, q;
  achr_pkg::achr_evt_t evt;
  achr_pkg::achr_cfg_t cfg;
  int                  err_count, comparisons, cyc;
  achr_regs i_dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .chipletResetIn, .evt, .cfg, .chipletReset, .chipletHalt,
    .cmdPulse, .handlerIrq);
  achr_evt_src i_src (.clk, .evt);
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t addr %h got %h exp %h", $time, paddr, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    q = prdata;
    qErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Idle cycle so the next call never re-drives psel in this time step
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'h1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'h0, 8'h00);
    cmp(q, {24'h00_0000, e});
  endtask
  initial begin
    {nrst, psel, penable, pwrite, chipletResetIn} = '0;
    {paddr, pwdata, err_count, comparisons} = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    rd(8'h0C, 8'h01);
    rd(8'h1C, 8'h00);
    rd(8'h24, 8'h00);
    rd(8'h60, 8'hFF);
    rd(8'h74, 8'hFF);
    rd(8'h08, 8'h00);
    for (int a = 8'h2C; a <= 8'h44; a += 4) wr(8'(a), 8'(a + 1));
    for (int a = 8'h2C; a <= 8'h44; a += 4) rd(8'(a), 8'(a + 1));
    cmp(cfg[63:32], 32'h002D_3141);
    cmp(cfg[31:0], 32'h3D39_3545);
    wr(8'h0C, 8'h00);
    wr(8'h08, 8'h0D);
    i_src.burst(11, 2);
    i_src.burst(12, 300);
    rd(8'h4C, 8'h2C);
    rd(8'h00, 8'h01);
    rd(8'h04, 8'h00);
    rd(8'h48, 8'h2C);
    rd(8'h00, 8'h01);
    rd(8'h4C, 8'h00);
    rd(8'h54, 8'h00);
    wr(8'h60, 8'h00);
    wr(8'h64, 8'h02);
    wr(8'h70, 8'h00);
    wr(8'h74, 8'h01);
    i_src.burst(10, 3);
    i_src.burst(9, 2);
    rd(8'h5C, 8'h03);
    rd(8'h6C, 8'h02);
    rd(8'h20, 8'h28);
    wr(8'h24, 8'h08);
    wr(8'h1C, 8'h02);
    repeat (2) @(posedge clk);
    cmp({31'h0000_0000, handlerIrq}, 32'h0000_0001);
    rd(8'h18, 8'h02);
    wr(8'h20, 8'h28);
    rd(8'h20, 8'h00);
    rd(8'h18, 8'h00);
    i_src.burst(8, 1);
    rd(8'h18, 8'h01);
    cmp({31'h0000_0000, handlerIrq}, 32'h0000_0000);
    i_src.burst(2, 1);
    rd(8'h14, 8'h04);
    rd(8'h14, 8'h04);
    wr(8'h28, 8'h02);
    rd(8'h14, 8'h04);
    rd(8'h14, 8'h00);
    wr(8'h10, 8'h5A);
    rd(8'h10, 8'h00);
    xfer(8'h80, 1'h0, 8'h00);
    cmp({31'h0000_0000, qErr}, 32'h0000_0001);
    wr(8'h0C, 8'h02);
    rd(8'h0C, 8'h02);
    chipletResetIn <= 1'h1;
    @(posedge clk);
    chipletResetIn <= 1'h0;
    rd(8'h0C, 8'h01);
    i_src.burst(12, 2);
    rd(8'h4C, 8'h00);
    finish_test();
  end
endmodule
